// File: src/tls_map.vh
// tls_map.vh: register offsets, field codes and reset values of the torque limit selector
// assumes: included by bare name by the selector design files
`ifndef TLS_MAP_VH
`define TLS_MAP_VH
// register word byte addresses (avalon, 32-bit words)
`define TLS_ADDR_W 6
`define TLS_OFS_CURVE 6'h00
`define TLS_OFS_SOURCE 6'h04
`define TLS_OFS_LIM1 6'h08
`define TLS_OFS_LIM2 6'h0c
`define TLS_OFS_LIM3 6'h10
`define TLS_OFS_LIM4 6'h14
`define TLS_OFS_RAMP_HOLD 6'h18
`define TLS_OFS_CNT_ROT 6'h1c
`define TLS_OFS_IN_FUNC 6'h20
`define TLS_OFS_OUT_FUNC 6'h24
`define TLS_OFS_MAX_TRQ 6'h28
`define TLS_OFS_OPTION 6'h2c
`define TLS_OFS_STATUS 6'h30
`define TLS_OFS_IRQ_STAT 6'h34
`define TLS_OFS_IRQ_MASK 6'h38
`define TLS_OFS_ACTIVE_LIM 6'h3c
// codes
`define TLS_CURVE_SLV 8'h03
`define TLS_SRC_QUAD 8'h00
`define TLS_SRC_TERM 8'h01
`define TLS_SRC_ANALOG 8'h02
`define TLS_SRC_OPT1 8'h03
`define TLS_SRC_OPT2 8'h04
`define TLS_EN_OFF 8'h00
`define TLS_EN_ON 8'h01
`define TLS_FN_LIMIT_EN 8'h28
`define TLS_FN_SWITCH_1 8'h29
`define TLS_FN_SWITCH_2 8'h2a
`define TLS_FN_LIMIT_ACT 8'h0a
// limit scaling: percent units, 200 percent at full scale
`define TLS_PCT_FULL 16'h00c8
`define TLS_PCT_MAX_CFG 8'h96
`define TLS_ADC_FULL 16'h0fff
// reset values
`define TLS_RST_LIM 8'h64
`define TLS_RST_MAX_TRQ 8'hc8
`define TLS_RST_FUNC 8'hff
// status bits
`define TLS_ST_ACTIVE 0
`define TLS_ST_HOLD 1
`define TLS_ST_SUPPRESS 2
`define TLS_ST_BADSRC 3
`define TLS_IRQ_W 4
`endif

// File: src/tls_quadrant_pick.v
// tls_quadrant_pick.v: picks one of four stored limits by index
// assumes: same-clock inputs; index encodes the limit number minus one
`include "tls_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tls_quadrant_pick #(
   parameter W = 8
) (
   input wire [1:0] sel_i,
   input wire [4*W-1:0] lims_i,
   output wire [W-1:0] lim_o
);
   // plain indexed mux; storage stays in the register file
   assign lim_o = lims_i[sel_i*W +: W];
endmodule // tls_quadrant_pick
`default_nettype wire

// File: src/tls_torque_limit_selector.v
// tls_torque_limit_selector.v: torque limit selection, limit status, ramp hold, reverse guard
// assumes: avalon-mm master on core_clk_i; terminal pins asynchronous; analog code 0..full=0..10 V
// Function
// - limiting only under sensorless vector curve
// - decode source: quadrant, terminal, analog, options
// - quadrant mode maps quadrant to limit
// - terminal mode: switch-chosen limit everywhere
// - analog 0..10 V gives 0..200 percent
// - option modes valid only with board
// - enable input off means maximum torque
// - no enable terminal: limiting always active
// - limits are ratios, 200 percent full
// - status output on while limiting operates
// - input codes 41, 42 are switches
// - suppress opposite-direction frequency when enabled
// - hold deceleration ramp while limiting
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`include "tls_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tls_torque_limit_selector #(
   parameter NIN = 8,
   parameter NOUT = 5,
   parameter AW = 12
) (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire [`TLS_ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   input wire [NIN-1:0] input_terminal_i,
   input wire [AW-1:0] analog_limit_input_i,
   input wire [1:0] quadrant_i,
   input wire option_board_fitted_i,
   input wire [7:0] option_limit_1_i,
   input wire [7:0] option_limit_2_i,
   input wire [15:0] torque_est_i,
   input wire run_reverse_i,
   input wire freq_reverse_i,
   input wire decelerating_i,
   output reg [7:0] torque_limit_o,
   output reg limit_active_output_o,
   output reg [NOUT-1:0] output_terminal_o,
   output reg ramp_hold_o,
   output reg freq_suppress_o,
   output wire irq_o
);
   reg [7:0] control_curve_select_q;
   reg [7:0] limit_source_select_q;
   reg [7:0] limit_value_q [0:3];
   reg [7:0] ramp_hold_on_limit_enable_q;
   reg [7:0] counter_rotation_prevent_enable_q;
   reg [7:0] input_terminal_function_q [0:NIN-1];
   reg [7:0] output_terminal_function_q [0:NOUT-1];
   reg [7:0] max_torque_q;
   reg [`TLS_IRQ_W-1:0] irq_stat_q;
   reg [`TLS_IRQ_W-1:0] irq_mask_q;
   reg [NIN-1:0] pin_meta_q;
   reg [NIN-1:0] pin_sync_q;
   reg [AW-1:0] ana_meta_q;
   reg [AW-1:0] ana_sync_q;
   reg [AW-1:0] ana_prev_q;
   reg [AW-1:0] ana_hold_q;
   reg [`TLS_IRQ_W-1:0] evt_prev_q;
   reg rd_pending_q;
   reg [31:0] rd_d;
   reg [7:0] sel_lim_d;
   reg [7:0] lim_d;
   reg src_ok_d;
   reg active_d;
   reg [1:0] pick_d;
   reg [31:0] wmask_d;
   wire [7:0] stored_lim;
   wire [AW+7:0] ana_prod;
   wire [AW+7:0] ana_quot;
   wire [7:0] ana_pct;
   wire [`TLS_IRQ_W-1:0] evt;
   wire slv;
   wire [NIN-1:0] fn_en, fn_s1, fn_s2, fn_asg;
   wire [NOUT-1:0] fn_act;
   wire has_en, en_on, sw1, sw2, wr_hit, rd_hit;
   integer k;
   genvar g;

   // pins pass two flip-flops before any logic looks at them; the analog word is
   // only taken once two synced samples agree, so a code caught mid-change is dropped
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         pin_meta_q <= {NIN{1'b0}};
         pin_sync_q <= {NIN{1'b0}};
         ana_meta_q <= {AW{1'b0}};
         ana_sync_q <= {AW{1'b0}};
         ana_prev_q <= {AW{1'b0}};
         ana_hold_q <= {AW{1'b0}};
      end else begin
         pin_meta_q <= input_terminal_i;
         pin_sync_q <= pin_meta_q;
         ana_meta_q <= analog_limit_input_i;
         ana_sync_q <= ana_meta_q;
         ana_prev_q <= ana_sync_q;
         if (ana_sync_q == ana_prev_q)
            ana_hold_q <= ana_sync_q;
      end
   end

   // per-terminal function decode
   generate
      for (g = 0; g < NIN; g = g + 1) begin : g_in
         assign fn_asg[g] = (input_terminal_function_q[g] == `TLS_FN_LIMIT_EN);
         assign fn_en[g] = pin_sync_q[g] & (input_terminal_function_q[g] == `TLS_FN_LIMIT_EN);
         assign fn_s1[g] = (input_terminal_function_q[g] == `TLS_FN_SWITCH_1) & pin_sync_q[g];
         assign fn_s2[g] = (input_terminal_function_q[g] == `TLS_FN_SWITCH_2) & pin_sync_q[g];
      end
      for (g = 0; g < NOUT; g = g + 1) begin : g_out
         assign fn_act[g] = (output_terminal_function_q[g] == `TLS_FN_LIMIT_ACT);
      end
   endgenerate

   // an enable terminal counts as assigned if any function slot holds its code;
   // per-slot flags keep this sensitive to every slot, a function call here would not be
   assign has_en = |fn_asg;
   assign en_on = |fn_en;
   assign sw1 = |fn_s1;
   assign sw2 = |fn_s2;
   assign slv = (control_curve_select_q == `TLS_CURVE_SLV);

   // analog code scaled linearly so the full code lands exactly on 200 percent;
   // dividing by the full code, not a power of two, keeps the top of the range reachable
   assign ana_prod = ana_hold_q * `TLS_PCT_FULL;
   assign ana_quot = ana_prod / `TLS_ADC_FULL;
   assign ana_pct = ana_quot[7:0];

   tls_quadrant_pick #(
      .W(8)
   ) u_pick (
      .sel_i(pick_d),
      .lims_i({limit_value_q[3], limit_value_q[2], limit_value_q[1], limit_value_q[0]}),
      .lim_o(stored_lim)
   );

   // source decode and enable gating; the limit is a ratio code, never absolute torque
   always @* begin
      pick_d = 2'b00;
      sel_lim_d = max_torque_q;
      src_ok_d = 1'b1;
      case (limit_source_select_q)
         `TLS_SRC_QUAD: begin
            // quadrant: 0 fwd power, 1 rev regen, 2 rev power, 3 fwd regen
            pick_d = quadrant_i;
            sel_lim_d = stored_lim;
         end
         `TLS_SRC_TERM: begin
            pick_d = {sw2, sw1};
            sel_lim_d = stored_lim;
         end
         `TLS_SRC_ANALOG: begin
            sel_lim_d = ana_pct;
         end
         `TLS_SRC_OPT1: begin
            src_ok_d = option_board_fitted_i;
            sel_lim_d = option_board_fitted_i ? option_limit_1_i : max_torque_q;
         end
         `TLS_SRC_OPT2: begin
            src_ok_d = option_board_fitted_i;
            sel_lim_d = option_board_fitted_i ? option_limit_2_i : max_torque_q;
         end
         default: begin
            src_ok_d = 1'b0;
         end
      endcase
      // without an enable terminal the mode stays on; with one it follows the pin
      if (has_en && !en_on)
         lim_d = max_torque_q;
      else
         lim_d = sel_lim_d;
      if (!slv || !src_ok_d)
         lim_d = max_torque_q;
      // operating means the estimate reached the applied limit
      active_d = slv && src_ok_d && (!has_en || en_on) &&
                 (torque_est_i >= {8'h00, lim_d});
   end

   // drive-facing outputs, registered
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         torque_limit_o <= `TLS_RST_MAX_TRQ;
         limit_active_output_o <= 1'b0;
         output_terminal_o <= {NOUT{1'b0}};
         ramp_hold_o <= 1'b0;
         freq_suppress_o <= 1'b0;
      end else begin
         torque_limit_o <= lim_d;
         limit_active_output_o <= active_d;
         output_terminal_o <= fn_act & {NOUT{active_d}};
         // hold drops in the same cycle as the limit status, so the ramp resumes from the held value
         ramp_hold_o <= active_d && decelerating_i &&
                        (ramp_hold_on_limit_enable_q == `TLS_EN_ON);
         freq_suppress_o <= slv && (counter_rotation_prevent_enable_q == `TLS_EN_ON) &&
                            (run_reverse_i != freq_reverse_i);
      end
   end

   // events: rising edges of active, hold, suppress, and an invalid source
   assign evt = {slv & ~src_ok_d, freq_suppress_o, ramp_hold_o, limit_active_output_o};
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // one-wait-state answer: waitrequest only in the first cycle of a read
   assign rd_hit = avs_read_i && !rd_pending_q;
   assign avs_waitrequest_o = rd_hit;
   assign wr_hit = avs_write_i;

   always @* begin
      wmask_d = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      rd_d = 32'h0000_0000;
      case (avs_address_i)
         `TLS_OFS_CURVE: rd_d = {24'h000000, control_curve_select_q};
         `TLS_OFS_SOURCE: rd_d = {24'h000000, limit_source_select_q};
         `TLS_OFS_LIM1: rd_d = {24'h000000, limit_value_q[0]};
         `TLS_OFS_LIM2: rd_d = {24'h000000, limit_value_q[1]};
         `TLS_OFS_LIM3: rd_d = {24'h000000, limit_value_q[2]};
         `TLS_OFS_LIM4: rd_d = {24'h000000, limit_value_q[3]};
         `TLS_OFS_RAMP_HOLD: rd_d = {24'h000000, ramp_hold_on_limit_enable_q};
         `TLS_OFS_CNT_ROT: rd_d = {24'h000000, counter_rotation_prevent_enable_q};
         `TLS_OFS_IN_FUNC: rd_d = {24'h000000, input_terminal_function_q[0]};
         `TLS_OFS_OUT_FUNC: rd_d = {24'h000000, output_terminal_function_q[0]};
         `TLS_OFS_MAX_TRQ: rd_d = {24'h000000, max_torque_q};
         `TLS_OFS_OPTION: rd_d = {31'h00000000, option_board_fitted_i};
         `TLS_OFS_STATUS: rd_d = {28'h0000000, evt};
         `TLS_OFS_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
         `TLS_OFS_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
         `TLS_OFS_ACTIVE_LIM: rd_d = {24'h000000, torque_limit_o};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // register file; software keeps stored limits within 0..150 percent, not checked here
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         control_curve_select_q <= `TLS_CURVE_SLV;
         limit_source_select_q <= `TLS_SRC_QUAD;
         for (k = 0; k < 4; k = k + 1)
            limit_value_q[k] <= `TLS_RST_LIM;
         ramp_hold_on_limit_enable_q <= `TLS_EN_OFF;
         counter_rotation_prevent_enable_q <= `TLS_EN_OFF;
         for (k = 0; k < NIN; k = k + 1)
            input_terminal_function_q[k] <= `TLS_RST_FUNC;
         for (k = 0; k < NOUT; k = k + 1)
            output_terminal_function_q[k] <= `TLS_RST_FUNC;
         max_torque_q <= `TLS_RST_MAX_TRQ;
         irq_stat_q <= {`TLS_IRQ_W{1'b0}};
         irq_mask_q <= {`TLS_IRQ_W{1'b0}};
         evt_prev_q <= {`TLS_IRQ_W{1'b0}};
         rd_pending_q <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         evt_prev_q <= evt;
         rd_pending_q <= rd_hit;
         if (rd_hit)
            avs_readdata_o <= rd_d;
         if (wr_hit && avs_byteenable_i[0]) begin
            case (avs_address_i)
               `TLS_OFS_CURVE: control_curve_select_q <= avs_writedata_i[7:0];
               `TLS_OFS_SOURCE: limit_source_select_q <= avs_writedata_i[7:0];
               `TLS_OFS_LIM1: limit_value_q[0] <= avs_writedata_i[7:0];
               `TLS_OFS_LIM2: limit_value_q[1] <= avs_writedata_i[7:0];
               `TLS_OFS_LIM3: limit_value_q[2] <= avs_writedata_i[7:0];
               `TLS_OFS_LIM4: limit_value_q[3] <= avs_writedata_i[7:0];
               `TLS_OFS_RAMP_HOLD: ramp_hold_on_limit_enable_q <= avs_writedata_i[7:0];
               `TLS_OFS_CNT_ROT: counter_rotation_prevent_enable_q <= avs_writedata_i[7:0];
               `TLS_OFS_IN_FUNC: begin
                  // byte 1 names the terminal, byte 0 its function
                  for (k = 0; k < NIN; k = k + 1)
                     if (avs_writedata_i[15:8] == k[7:0])
                        input_terminal_function_q[k] <= avs_writedata_i[7:0];
               end
               `TLS_OFS_OUT_FUNC: begin
                  for (k = 0; k < NOUT; k = k + 1)
                     if (avs_writedata_i[15:8] == k[7:0])
                        output_terminal_function_q[k] <= avs_writedata_i[7:0];
               end
               `TLS_OFS_MAX_TRQ: max_torque_q <= avs_writedata_i[7:0];
               `TLS_OFS_IRQ_MASK: irq_mask_q <= avs_writedata_i[`TLS_IRQ_W-1:0];
               default: ;
            endcase
         end
         // write-one-to-clear, a new edge in the same cycle wins
         if (wr_hit && avs_byteenable_i[0] && avs_address_i == `TLS_OFS_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~(avs_writedata_i[`TLS_IRQ_W-1:0] & wmask_d[`TLS_IRQ_W-1:0]))
                          | (evt & ~evt_prev_q);
         else
            irq_stat_q <= irq_stat_q | (evt & ~evt_prev_q);
      end
   end
endmodule // tls_torque_limit_selector
`default_nettype wire

// File: bench/tls_selector_properties.sv
// tls_selector_properties.sv: port-level assertions for the torque limit selector
// assumes: bound to tls_torque_limit_selector; outputs lag their causes by one clock
`timescale 1ns/1ps
`default_nettype none
module tls_selector_props #(
   parameter NOUT = 5
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic avs_read_i,
   input wire logic avs_waitrequest_o,
   input wire logic [15:0] torque_est_i,
   input wire logic run_reverse_i,
   input wire logic freq_reverse_i,
   input wire logic decelerating_i,
   input wire logic [7:0] torque_limit_o,
   input wire logic limit_active_output_o,
   input wire logic [NOUT-1:0] output_terminal_o,
   input wire logic ramp_hold_o,
   input wire logic freq_suppress_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // one- and two-cycle behaviours: a read in its wait cycle, limiting that just stopped
   sequence s_read_wait; avs_read_i && avs_waitrequest_o; endsequence
   sequence s_limit_drop; limit_active_output_o ##1 !limit_active_output_o; endsequence
   property p_wait_read; avs_waitrequest_o |-> avs_read_i; endproperty
   a_wait_read: assert property (p_wait_read) else $error("wait raised outside a read");
   property p_first_wait; $rose(avs_read_i) |-> avs_waitrequest_o; endproperty
   a_first_wait: assert property (p_first_wait) else $error("read answered without wait");
   property p_one_wait; s_read_wait |=> !avs_waitrequest_o; endproperty
   a_one_wait: assert property (p_one_wait) else $error("read wait longer than one cycle");
   property p_reset_out; $rose(rst_b_i) |-> torque_limit_o == 8'hc8 && !limit_active_output_o; endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not at reset level");
   // limiting is reported only when the estimate has reached the applied limit
   property p_active_cause; limit_active_output_o |-> $past(torque_est_i) >= {8'h00, torque_limit_o}; endproperty
   a_active_cause: assert property (p_active_cause) else $error("active below limit");
   property p_term_out; (output_terminal_o != '0) |-> limit_active_output_o; endproperty
   a_term_out: assert property (p_term_out) else $error("status pin without limiting");
   property p_hold_cause; ramp_hold_o |-> limit_active_output_o && $past(decelerating_i); endproperty
   a_hold_cause: assert property (p_hold_cause) else $error("ramp held without cause");
   property p_resume; s_limit_drop |-> !ramp_hold_o; endproperty
   a_resume: assert property (p_resume) else $error("ramp still held after limiting");
   property p_suppress; freq_suppress_o |-> $past(freq_reverse_i != run_reverse_i); endproperty
   a_suppress: assert property (p_suppress) else $error("suppress without reversal");
endmodule // tls_selector_props
bind tls_torque_limit_selector tls_selector_props #(.NOUT(NOUT)) tls_selector_props_i (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avs_read_i(avs_read_i),
   .avs_waitrequest_o(avs_waitrequest_o), .torque_est_i(torque_est_i), .run_reverse_i(run_reverse_i),
   .freq_reverse_i(freq_reverse_i), .decelerating_i(decelerating_i), .torque_limit_o(torque_limit_o),
   .limit_active_output_o(limit_active_output_o), .output_terminal_o(output_terminal_o),
   .ramp_hold_o(ramp_hold_o), .freq_suppress_o(freq_suppress_o)
);
`default_nettype wire

// File: bench/tls_drive_model.sv
// tls_drive_model.sv: behavioural motor drive, terminal pins and analog source
// assumes: bench commands change right after a rising edge of core_clk_i
`timescale 1ns/1ps
`default_nettype none
module tls_drive_model (
   input wire logic core_clk_i,
   input wire logic [1:0] quad_cmd_i,
   input wire logic [15:0] trq_cmd_i,
   input wire logic decel_cmd_i,
   input wire logic slip_cmd_i,
   input wire logic [7:0] pin_cmd_i,
   input wire logic [11:0] ana_cmd_i,
   output logic [1:0] quadrant_o,
   output logic [15:0] torque_est_o,
   output logic decelerating_o,
   output logic run_reverse_o,
   output logic freq_reverse_o,
   output logic [7:0] terminal_o,
   output logic [11:0] analog_o
);
   initial {quadrant_o, torque_est_o, decelerating_o, run_reverse_o, freq_reverse_o, terminal_o, analog_o} = '0;
   // the drive answers a cycle late; reverse run in quadrants 1 and 2, slip turns the rotor the wrong way
   always @(posedge core_clk_i) begin
      quadrant_o <= quad_cmd_i;
      torque_est_o <= trq_cmd_i;
      decelerating_o <= decel_cmd_i;
      run_reverse_o <= ^quad_cmd_i;
      freq_reverse_o <= ^quad_cmd_i ^ slip_cmd_i;
      terminal_o <= pin_cmd_i;
      analog_o <= ana_cmd_i;
   end
endmodule // tls_drive_model
`default_nettype wire

// File: bench/tb_torque_limit_selector.sv
// tb_torque_limit_selector.sv: table-driven and hand-written checks of the torque limit selector
// assumes: tls_map.vh on the include path; design, model and checker compiled first
`include "tls_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_torque_limit_selector;
   typedef struct packed {logic [7:0] src; logic [1:0] quad; logic [1:0] sw; logic [11:0] ana; logic [7:0] lim;} tls_row_t;
   tls_row_t rows [12];
   logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, decel_c = 1'b0, slip_c = 1'b0, opt_fit = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic waitreq, irq, act, hold, supp, decel, rrev, frev;
   logic [7:0] lim, pins, pin_c = 8'h00;
   logic [4:0] outs;
   logic [1:0] quad, quad_c = 2'h0;
   logic [15:0] limit_active_output, trq_c = 16'h0000;
   logic [11:0] ana, ana_c = 12'h000;
   int fail_count = 0, compares = 0, cycles = 0;
   tls_drive_model tls_drive_model_i (.core_clk_i(clk), .quad_cmd_i(quad_c), .trq_cmd_i(trq_c), .decel_cmd_i(decel_c),
      .slip_cmd_i(slip_c), .pin_cmd_i(pin_c), .ana_cmd_i(ana_c), .quadrant_o(quad), .torque_est_o(limit_active_output),
      .decelerating_o(decel), .run_reverse_o(rrev), .freq_reverse_o(frev), .terminal_o(pins), .analog_o(ana));
   // option limits are fixed codes; the board-fitted flag is driven by the tests
   tls_torque_limit_selector tls_torque_limit_selector_i (.core_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .input_terminal_i(pins), .analog_limit_input_i(ana), .quadrant_i(quad),
      .option_board_fitted_i(opt_fit), .option_limit_1_i(8'h33), .option_limit_2_i(8'h44), .torque_est_i(limit_active_output),
      .run_reverse_i(rrev), .freq_reverse_i(frev), .decelerating_i(decel), .torque_limit_o(lim),
      .limit_active_output_o(act), .output_terminal_o(outs), .ramp_hold_o(hold), .freq_suppress_o(supp), .irq_o(irq));
   // 125 MHz clock
   initial begin
      forever #4 clk = ~clk;
   end
   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // request held until waitrequest is seen low; read data taken for that accepting edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      // waitrequest and read data are looked at on the rising edge, before the design updates them
      @(posedge clk);
      while (waitreq !== 1'b0) @(posedge clk);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // pins pass two sync stages, the drive one more register, analog one agreeing sample: six cycles
   task automatic settle;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask
   initial begin
      rows = '{'{8'h00, 2'h0, 2'h0, 12'h000, 8'h0a}, '{8'h00, 2'h1, 2'h3, 12'h000, 8'h14},
         '{8'h00, 2'h2, 2'h0, 12'h000, 8'h1e}, '{8'h00, 2'h3, 2'h1, 12'h000, 8'h28},
         '{8'h01, 2'h0, 2'h0, 12'h000, 8'h0a}, '{8'h01, 2'h3, 2'h1, 12'h000, 8'h14},
         '{8'h01, 2'h1, 2'h2, 12'h000, 8'h1e}, '{8'h01, 2'h2, 2'h3, 12'h000, 8'h28},
         '{8'h02, 2'h0, 2'h0, 12'h000, 8'h00}, '{8'h02, 2'h2, 2'h0, 12'h333, 8'h28},
         '{8'h02, 2'h1, 2'h0, 12'h999, 8'h78}, '{8'h02, 2'h3, 2'h0, 12'hfff, 8'hc8}};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, `TLS_OFS_LIM1, 32'h0);
      chk("lim1 reset", q, 32'h64);
      bus(1'b0, `TLS_OFS_CURVE, 32'h0);
      chk("curve reset", q, 32'h03);
      for (int i = 0; i < 4; i++) bus(1'b1, `TLS_OFS_LIM1 + 6'(4 * i), 32'(10 * (i + 1)));
      bus(1'b0, `TLS_OFS_LIM4, 32'h0);
      chk("lim4 readback", q, 32'h28);
      bus(1'b1, `TLS_OFS_IN_FUNC, {16'h0, 8'h06, `TLS_FN_SWITCH_1});
      bus(1'b1, `TLS_OFS_IN_FUNC, {16'h0, 8'h07, `TLS_FN_SWITCH_2});
      bus(1'b1, `TLS_OFS_OUT_FUNC, {16'h0, 8'h02, `TLS_FN_LIMIT_ACT});
      // table: source, quadrant, switches and analog code against the applied limit
      foreach (rows[i]) begin
         bus(1'b1, `TLS_OFS_SOURCE, {24'h0, rows[i].src});
         @(posedge clk);
         quad_c <= rows[i].quad;
         pin_c <= {rows[i].sw, 6'h00};
         ana_c <= rows[i].ana;
         settle();
         chk("row limit", lim, rows[i].lim);
      end
      // limiting at the exact limit, status pin, ramp hold and sticky interrupt
      bus(1'b1, `TLS_OFS_SOURCE, 32'h0);
      bus(1'b1, `TLS_OFS_RAMP_HOLD, 32'h1);
      // events left over from the table are cleared first, so the raise below is a fresh one
      bus(1'b1, `TLS_OFS_IRQ_STAT, 32'h0f);
      bus(1'b1, `TLS_OFS_IRQ_MASK, 32'h1);
      @(negedge clk);
      chk("irq idle", irq, 1'b0);
      @(posedge clk);
      quad_c <= 2'h0;
      trq_c <= 16'h000a;
      decel_c <= 1'b1;
      settle();
      chk("active", act, 1'b1);
      chk("status pin", outs, 5'h04);
      chk("ramp hold", hold, 1'b1);
      chk("irq raised", irq, 1'b1);
      @(posedge clk);
      trq_c <= 16'h0009;
      settle();
      chk("below limit", act, 1'b0);
      chk("ramp resumed", hold, 1'b0);
      chk("irq sticky", irq, 1'b1);
      bus(1'b0, `TLS_OFS_IRQ_STAT, 32'h0);
      chk("event bit", q[0], 1'b1);
      bus(1'b1, `TLS_OFS_IRQ_STAT, 32'h0f);
      settle();
      chk("irq cleared", irq, 1'b0);
      bus(1'b1, `TLS_OFS_IRQ_MASK, 32'h0);
      bus(1'b1, `TLS_OFS_RAMP_HOLD, 32'h0);
      @(posedge clk);
      trq_c <= 16'h000a;
      settle();
      chk("hold disabled", hold, 1'b0);
      chk("irq masked", irq, 1'b0);
      bus(1'b1, `TLS_OFS_IRQ_MASK, 32'h1);
      settle();
      chk("irq unmasked", irq, 1'b1);
      bus(1'b1, `TLS_OFS_IRQ_STAT, 32'h0f);
      // enable terminal off falls back to maximum torque
      bus(1'b1, `TLS_OFS_IN_FUNC, {24'h0, `TLS_FN_LIMIT_EN});
      settle();
      chk("enable off", lim, 8'hc8);
      chk("enable off idle", act, 1'b0);
      @(posedge clk);
      pin_c <= 8'h01;
      settle();
      chk("enable on", lim, 8'h0a);
      bus(1'b1, `TLS_OFS_IN_FUNC, {24'h0, `TLS_RST_FUNC});
      // option sources without the board, then an undefined source
      for (int s = 3; s < 6; s++) begin
         bus(1'b1, `TLS_OFS_SOURCE, 32'(s));
         settle();
         chk("option source", lim, 8'hc8);
      end
      // with the board fitted the option sources pass their own limits
      @(posedge clk);
      opt_fit <= 1'b1;
      for (int s = 3; s < 5; s++) begin
         bus(1'b1, `TLS_OFS_SOURCE, 32'(s));
         settle();
         chk("option fitted", lim, (s == 3) ? 32'h33 : 32'h44);
      end
      bus(1'b1, `TLS_OFS_SOURCE, 32'h0);
      @(posedge clk);
      opt_fit <= 1'b0;
      bus(1'b1, `TLS_OFS_CURVE, 32'h0);
      settle();
      chk("other curve", lim, 8'hc8);
      chk("other curve idle", act, 1'b0);
      bus(1'b1, `TLS_OFS_CURVE, 32'h3);
      bus(1'b1, `TLS_OFS_CNT_ROT, 32'h1);
      @(posedge clk);
      slip_c <= 1'b1;
      settle();
      chk("suppress on", supp, 1'b1);
      bus(1'b1, `TLS_OFS_CNT_ROT, 32'h0);
      settle();
      chk("suppress off", supp, 1'b0);
      stop_test();
   end
endmodule // tb_torque_limit_selector
`default_nettype wire
